/* include/bsid_cfg.svh */
// Constants of the boundary-scan instruction decoder
`ifndef BSID_CFG_SVH
`define BSID_CFG_SVH

// Instruction register length and codes
`define BSID_IR_LEN 10
`define BSID_IR_SAMPLE 10'h005
`define BSID_IR_EXTEST 10'h00f
`define BSID_IR_BYPASS 10'h3ff
`define BSID_IR_USERCODE 10'h007
`define BSID_IR_IDCODE 10'h006
`define BSID_IR_HIGHZ 10'h00b
`define BSID_IR_CLAMP 10'h00a
`define BSID_IR_RECONFIG 10'h001
// Value loaded at capture-IR: low bits 01, decodes as bypass
`define BSID_IR_CAPT 10'h3fd

// Identification value: arbitrary, LSB set as a marker bit
`define BSID_IDCODE_VAL 32'h0abc_d001
`define BSID_DR32_LEN 32

// Scanned user pins and the three cells that each pin owns
`define BSID_PINS 8
`define BSID_CELL_W 3
`define BSID_CELL_IN 0
`define BSID_CELL_OUT 1
`define BSID_CELL_OE 2
`define BSID_BSR_LEN 24

`endif

/* include/bsid_pkg.sv */
// Types and shared functions of the boundary-scan instruction decoder
`default_nettype none
`include "bsid_cfg.svh"
package bsid_pkg;

    // Test-access controller states
    typedef enum logic [3:0] {
        BSID_TLR, BSID_RTI, BSID_SEL_DR, BSID_CAP_DR, BSID_SH_DR,
        BSID_EX1_DR, BSID_PA_DR, BSID_EX2_DR, BSID_UPD_DR,
        BSID_SEL_IR, BSID_CAP_IR, BSID_SH_IR, BSID_EX1_IR,
        BSID_PA_IR, BSID_EX2_IR, BSID_UPD_IR
    } bsid_tap_state_t;

    // Decoded instruction
    typedef enum logic [2:0] {
        MODE_BYPASS, MODE_SAMPLE, MODE_EXTEST, MODE_USERCODE,
        MODE_IDCODE, MODE_HIGHZ, MODE_CLAMP, MODE_RECONFIG
    } bsid_mode_t;

    // State of the controller module
    typedef struct packed {
        bsid_tap_state_t state;
    } bsid_tap_st_t;

    // State of the decoder top
    typedef struct packed {
        logic tck_s1;
        logic tck_s2;
        logic tck_s3;
        logic tms_s1;
        logic tms_s2;
        logic tdi_s1;
        logic tdi_s2;
        logic trst_n_s1;
        logic trst_n_s2;
        logic [`BSID_PINS-1:0] pin_s1;
        logic [`BSID_PINS-1:0] pin_s2;
        logic [`BSID_IR_LEN-1:0] ir_sh;
        logic [`BSID_IR_LEN-1:0] ir;
        bsid_mode_t mode;
        logic bypass;
        logic [`BSID_DR32_LEN-1:0] idsh;
        logic [`BSID_BSR_LEN-1:0] bsr;
        logic [`BSID_BSR_LEN-1:0] bsr_upd;
        logic tdo;
        logic tdo_oe;
        logic [`BSID_PINS-1:0] pad_out;
        logic [`BSID_PINS-1:0] pad_oe;
        logic reconfig;
    } bsid_core_st_t;

    // Instruction code to mode; anything unlisted falls to bypass
    function automatic bsid_mode_t bsid_decode(
        logic [`BSID_IR_LEN-1:0] code);
        case (code)
            `BSID_IR_SAMPLE: return MODE_SAMPLE;
            `BSID_IR_EXTEST: return MODE_EXTEST;
            `BSID_IR_USERCODE: return MODE_USERCODE;
            `BSID_IR_IDCODE: return MODE_IDCODE;
            `BSID_IR_HIGHZ: return MODE_HIGHZ;
            `BSID_IR_CLAMP: return MODE_CLAMP;
            `BSID_IR_RECONFIG: return MODE_RECONFIG;
            default: return MODE_BYPASS;
        endcase
    endfunction

    // One cell kind of every pin, pulled out of a boundary vector
    function automatic logic [`BSID_PINS-1:0] bsid_pin_field(
        logic [`BSID_BSR_LEN-1:0] v, int k);
        logic [`BSID_PINS-1:0] r;
        r = '0;
        for (int i = 0; i < `BSID_PINS; i++) begin
            r[i] = v[`BSID_CELL_W * i + k];
        end
        return r;
    endfunction

endpackage
`default_nettype wire

/* include/bsid_tap_if.sv */
// Link between the decoder top and its test-access controller
`default_nettype none
interface bsid_tap_if;
    logic tck_rise; // One core cycle per test clock rising edge
    logic tms; // Synchronised mode select
    logic trst; // Test reset, active high
    bsid_pkg::bsid_tap_state_t state; // Controller state

    modport ctrl(output tck_rise, output tms, output trst, input state);
    modport tap(input tck_rise, input tms, input trst, output state);
endinterface
`default_nettype wire

/* hdl/bsid_tap.sv */
// Test-access controller state machine, stepped on test clock edges
`default_nettype none
module bsid_tap (
    input wire logic core_clk,
    input wire logic reset,
    bsid_tap_if.tap link
);
    import bsid_pkg::*;

    bsid_tap_st_t s; // Registered state
    bsid_tap_st_t next_s; // Next state

    // Standard sixteen-state walk under the mode select
    function automatic bsid_tap_state_t step(bsid_tap_state_t c,
        logic m);
        case (c)
            BSID_TLR: return m ? BSID_TLR : BSID_RTI;
            BSID_RTI: return m ? BSID_SEL_DR : BSID_RTI;
            BSID_SEL_DR: return m ? BSID_SEL_IR : BSID_CAP_DR;
            BSID_CAP_DR: return m ? BSID_EX1_DR : BSID_SH_DR;
            BSID_SH_DR: return m ? BSID_EX1_DR : BSID_SH_DR;
            BSID_EX1_DR: return m ? BSID_UPD_DR : BSID_PA_DR;
            BSID_PA_DR: return m ? BSID_EX2_DR : BSID_PA_DR;
            BSID_EX2_DR: return m ? BSID_UPD_DR : BSID_SH_DR;
            BSID_UPD_DR: return m ? BSID_SEL_DR : BSID_RTI;
            BSID_SEL_IR: return m ? BSID_TLR : BSID_CAP_IR;
            BSID_CAP_IR: return m ? BSID_EX1_IR : BSID_SH_IR;
            BSID_SH_IR: return m ? BSID_EX1_IR : BSID_SH_IR;
            BSID_EX1_IR: return m ? BSID_UPD_IR : BSID_PA_IR;
            BSID_PA_IR: return m ? BSID_EX2_IR : BSID_PA_IR;
            BSID_EX2_IR: return m ? BSID_UPD_IR : BSID_SH_IR;
            BSID_UPD_IR: return m ? BSID_SEL_DR : BSID_RTI;
            default: return BSID_TLR;
        endcase
    endfunction

    // Advance only on a test clock edge; test reset wins
    always_comb begin
        next_s = s;
        if (link.trst) begin
            next_s.state = BSID_TLR;
        end else if (link.tck_rise) begin
            next_s.state = step(s.state, link.tms); // R9
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link.state = s.state;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_trst_to_reset: assert property ( // R9
        link.trst |=> link.state == BSID_TLR)
        else $error("test reset did not reach reset state");

    a_hold_no_edge: assert property ( // R9
        !link.tck_rise && !link.trst |=> $stable(link.state))
        else $error("controller moved without a test clock edge");
endmodule
`default_nettype wire

/* hdl/bsid_top.sv */
// Boundary-scan instruction decoder with its scan chains and pin control
//
// Notes on behaviour
// R1: Sample/preload captures pins, loads pattern, pins normal
// R2: External test drives pattern, captures input pins
// R3: Bypass instruction puts one-bit register between TDI/TDO
// R4: User code shifts 32-bit user value out
// R5: Identification code shifts identification value out
// R6: High-impedance: bypass selected, all pins tri-stated
// R7: Clamp: bypass selected, pins held from scan register
// R8: Reconfig instruction pulses internal restart, pin untouched
// R9: New instruction takes effect only at update
// R10: Unlisted instruction codes behave as bypass
`default_nettype none
`include "bsid_cfg.svh"
module bsid_top (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [`BSID_DR32_LEN-1:0] user_code,
    input wire logic [`BSID_PINS-1:0] core_out,
    input wire logic [`BSID_PINS-1:0] core_oe,
    input wire logic [`BSID_PINS-1:0] pad_in,
    output logic [`BSID_PINS-1:0] pad_out,
    output logic [`BSID_PINS-1:0] pad_oe,
    output logic reconfig_req,
    output bsid_pkg::bsid_mode_t active_mode
);
    import bsid_pkg::*;

    bsid_core_st_t s; // Registered state
    bsid_core_st_t next_s; // Next state
    logic tck_rise; // Test clock rising edge seen this cycle
    logic tck_fall; // Test clock falling edge seen this cycle
    bsid_tap_if tap_link(); // Controller link

    // Edges come from the second and third stages only
    assign tck_rise = s.tck_s2 & ~s.tck_s3;
    assign tck_fall = ~s.tck_s2 & s.tck_s3;
    assign tap_link.tck_rise = tck_rise;
    assign tap_link.tms = s.tms_s2;
    assign tap_link.trst = ~s.trst_n_s2;

    // Controller state machine
    bsid_tap u_tap (
        .core_clk(core_clk),
        .reset(reset),
        .link(tap_link.tap)
    );

    // Whole next-state computation
    always_comb begin
        logic [`BSID_BSR_LEN-1:0] cap;
        cap = '0;
        next_s = s;
        // Two-stage synchronisers for every pin input, and a third stage for the test clock
        next_s.tck_s1 = tck;
        next_s.tck_s2 = s.tck_s1;
        next_s.tck_s3 = s.tck_s2;
        next_s.tms_s1 = tms;
        next_s.tms_s2 = s.tms_s1;
        next_s.tdi_s1 = tdi;
        next_s.tdi_s2 = s.tdi_s1;
        next_s.trst_n_s1 = trst_n;
        next_s.trst_n_s2 = s.trst_n_s1;
        next_s.pin_s1 = pad_in;
        next_s.pin_s2 = s.pin_s1;
        next_s.reconfig = 1'b0;
        // Capture image: pad level, core output, core enable
        for (int i = 0; i < `BSID_PINS; i++) begin
            cap[`BSID_CELL_W * i + `BSID_CELL_IN] = s.pin_s2[i];
            cap[`BSID_CELL_W * i + `BSID_CELL_OUT] = core_out[i];
            cap[`BSID_CELL_W * i + `BSID_CELL_OE] = core_oe[i];
        end
        // Work done as the test clock rises in each state
        if (tck_rise) begin
            case (tap_link.state)
                BSID_CAP_IR: begin
                    next_s.ir_sh = `BSID_IR_CAPT;
                end
                BSID_SH_IR: begin
                    next_s.ir_sh = {s.tdi_s2, s.ir_sh[`BSID_IR_LEN-1:1]};
                end
                BSID_UPD_IR: begin
                    // Only here does a shifted code take effect
                    next_s.ir = s.ir_sh; // R9
                    next_s.mode = bsid_decode(s.ir_sh); // R10
                    if (bsid_decode(s.ir_sh) == MODE_RECONFIG) begin
                        next_s.reconfig = 1'b1; // R8
                    end
                end
                BSID_CAP_DR: begin
                    case (s.mode)
                        MODE_IDCODE: next_s.idsh = `BSID_IDCODE_VAL; // R5
                        MODE_USERCODE: next_s.idsh = user_code; // R4
                        MODE_SAMPLE, MODE_EXTEST: next_s.bsr = cap; // R1 R2
                        default: next_s.bypass = 1'b0; // R3 R6 R7
                    endcase
                end
                BSID_SH_DR: begin
                    case (s.mode)
                        MODE_IDCODE, MODE_USERCODE: begin
                            next_s.idsh = {s.tdi_s2,
                                s.idsh[`BSID_DR32_LEN-1:1]}; // R4 R5
                        end
                        MODE_SAMPLE, MODE_EXTEST: begin
                            next_s.bsr = {s.tdi_s2,
                                s.bsr[`BSID_BSR_LEN-1:1]}; // R1 R2
                        end
                        default: next_s.bypass = s.tdi_s2; // R3
                    endcase
                end
                BSID_UPD_DR: begin
                    // Preload and pattern load; clamp keeps old image
                    if (s.mode == MODE_SAMPLE || s.mode == MODE_EXTEST) begin
                        next_s.bsr_upd = s.bsr; // R1 R2
                    end
                end
                default: begin
                end
            endcase
        end
        // Reset state always points the chain at identification
        if (tap_link.state == BSID_TLR) begin
            next_s.ir = `BSID_IR_IDCODE;
            next_s.mode = MODE_IDCODE;
        end
        // Serial output changes on the falling test clock edge
        if (tck_fall) begin
            case (tap_link.state)
                BSID_SH_IR: begin
                    next_s.tdo = s.ir_sh[0];
                    next_s.tdo_oe = 1'b1;
                end
                BSID_SH_DR: begin
                    case (s.mode)
                        MODE_IDCODE, MODE_USERCODE: next_s.tdo = s.idsh[0];
                        MODE_SAMPLE, MODE_EXTEST: next_s.tdo = s.bsr[0];
                        default: next_s.tdo = s.bypass; // R3
                    endcase
                    next_s.tdo_oe = 1'b1;
                end
                default: next_s.tdo_oe = 1'b0;
            endcase
        end
        // Pin drive by mode; the core keeps the pins otherwise
        case (s.mode)
            MODE_EXTEST, MODE_CLAMP: begin
                next_s.pad_out = bsid_pin_field(s.bsr_upd,
                    `BSID_CELL_OUT); // R2 R7
                next_s.pad_oe = bsid_pin_field(s.bsr_upd,
                    `BSID_CELL_OE); // R2 R7
            end
            MODE_HIGHZ: begin
                next_s.pad_out = core_out;
                next_s.pad_oe = '0; // R6
            end
            default: begin
                next_s.pad_out = core_out; // R1 R3 R10
                next_s.pad_oe = core_oe;
            end
        endcase
    end

    // State register; the chain comes up on identification
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s <= '0;
            s.ir <= `BSID_IR_IDCODE;
            s.mode <= MODE_IDCODE;
        end else begin
            s <= next_s;
        end
    end

    // Every output straight from the state register
    assign tdo = s.tdo;
    assign tdo_oe = s.tdo_oe;
    assign pad_out = s.pad_out;
    assign pad_oe = s.pad_oe;
    assign reconfig_req = s.reconfig;
    assign active_mode = s.mode;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Instruction update edge, and a one-cycle restart pulse
    sequence upd_ir_edge;
        tck_rise && tap_link.state == BSID_UPD_IR;
    endsequence

    sequence reconfig_one_cycle;
        reconfig_req ##1 !reconfig_req;
    endsequence

    a_ir_on_update: assert property ( // R9
        !$stable(s.ir) |-> $past(tck_rise && tap_link.state == BSID_UPD_IR)
            || $past(tap_link.state == BSID_TLR))
        else $error("instruction changed outside update");

    a_unknown_bypass: assert property ( // R10
        upd_ir_edge and !(s.ir_sh inside {`BSID_IR_SAMPLE,
            `BSID_IR_EXTEST, `BSID_IR_USERCODE, `BSID_IR_IDCODE,
            `BSID_IR_HIGHZ, `BSID_IR_CLAMP, `BSID_IR_RECONFIG})
        |=> active_mode == MODE_BYPASS ##1 pad_oe == $past(core_oe))
        else $error("unlisted code did not act as bypass");

    a_reconfig_pulse: assert property ( // R8
        upd_ir_edge and s.ir_sh == `BSID_IR_RECONFIG
        |=> reconfig_one_cycle)
        else $error("reconfig request not a single pulse");

    a_highz_pins: assert property ( // R6
        s.mode == MODE_HIGHZ |=> pad_oe == '0)
        else $error("pins driven in high-impedance mode");

    a_clamp_hold: assert property ( // R7
        s.mode == MODE_CLAMP |=> pad_out ==
            bsid_pin_field($past(s.bsr_upd), `BSID_CELL_OUT))
        else $error("clamp did not hold scan register value");

    a_extest_drive: assert property ( // R2
        s.mode == MODE_EXTEST |=> pad_oe ==
            bsid_pin_field($past(s.bsr_upd), `BSID_CELL_OE))
        else $error("external test pattern not driven");

    a_sample_normal: assert property ( // R1
        s.mode == MODE_SAMPLE |=> pad_out == $past(core_out)
            && pad_oe == $past(core_oe))
        else $error("sample disturbed normal pin drive");

    a_sample_capture: assert property ( // R1
        tck_rise && tap_link.state == BSID_CAP_DR && s.mode == MODE_SAMPLE
        |=> bsid_pin_field(s.bsr, `BSID_CELL_IN) == $past(s.pin_s2))
        else $error("pin snapshot not captured");

    a_bypass_pass: assert property ( // R3
        tck_rise && tap_link.state == BSID_SH_DR && s.mode == MODE_BYPASS
        |=> s.bypass == $past(s.tdi_s2))
        else $error("bypass bit did not follow serial input");

    a_idcode_load: assert property ( // R5
        tck_rise && tap_link.state == BSID_CAP_DR && s.mode == MODE_IDCODE
        |=> s.idsh == `BSID_IDCODE_VAL)
        else $error("identification value not loaded");

    a_usercode_load: assert property ( // R4
        tck_rise && tap_link.state == BSID_CAP_DR
            && s.mode == MODE_USERCODE
        |=> s.idsh == $past(user_code))
        else $error("user code not loaded");
endmodule
`default_nettype wire

/* sim/bsid_ctl_model.sv */
// Model of the external test-access controller that drives the scan port
`default_nettype none
module bsid_ctl_model (
    input wire logic core_clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ns;

    // Half test clock period in core cycles: 200 ns at 20 MHz
    localparam int HALF = 4;

    // Test clock rests low between operations
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One test clock period; tdo is read just before the rising edge,
    // since the device moves it only after a falling edge
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge core_clk);
        tms <= m;
        tdi <= d;
        repeat (HALF - 1) @(posedge core_clk);
        o = tdo;
        tck <= 1'b1;
        repeat (HALF) @(posedge core_clk);
        tck <= 1'b0;
    endtask

    // Five high mode bits reach reset from any state, then idle
    task automatic reset_tap;
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    // Idle to instruction shift, ten bits LSB first, stop in update
    task automatic ir_shift(input logic [9:0] code, output logic [9:0] cap);
        logic o;
        step(1'b1, 1'b0, o);
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < 10; i++) begin
            step(i == 9, code[i], o);
            cap[i] = o;
        end
        step(1'b1, 1'b0, o);
    endtask

    // Full instruction load: the rise leaving update makes it act
    task automatic load_ir(input logic [9:0] code, output logic [9:0] cap);
        logic o;
        ir_shift(code, cap);
        step(1'b0, 1'b0, o);
    endtask

    // Data shift of n bits LSB first, through update, back to idle
    task automatic dr_shift(input int n, input logic [31:0] din,
                            output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the boundary-scan instruction decoder
`default_nettype none
`include "bsid_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import bsid_pkg::*;

    logic core_clk;
    logic reset;
    logic trst_n;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic [31:0] user_code;
    logic [7:0] core_out;
    logic [7:0] core_oe;
    logic [7:0] pad_in;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic reconfig_req;
    bsid_mode_t active_mode;
    bsid_mode_t pulse_mode; // Mode seen beside the last restart pulse
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int pulses = 0; // Core cycles with the restart request high
    logic [9:0] cap;
    logic [31:0] dout;
    wire tdo_line;

    // Board pull-up holds the line high while the device lets go
    assign tdo_line = tdo_oe ? tdo : 1'b1;

    bsid_top dut (.core_clk(core_clk), .reset(reset), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
        .tdo_oe(tdo_oe), .user_code(user_code), .core_out(core_out),
        .core_oe(core_oe), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .reconfig_req(reconfig_req),
        .active_mode(active_mode));

    bsid_ctl_model ctl (.core_clk(core_clk), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo_line));

    // 20 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Timeout guard and restart pulse watch
    always @(posedge core_clk) begin
        cycles++;
        if (reconfig_req === 1'b1) begin
            pulses++;
            pulse_mode = active_mode;
        end
        if (cycles == 30000) begin
            fails++;
            $display("BAD timeout expected finish seen hang");
            test_done();
        end
    end

    // Shared comparison with mismatch report
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Let an update reach the pins, then sample between edges
    task automatic settle;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // Boundary pattern from pin out and enable cells
    function automatic logic [23:0] mk_bsr(logic [7:0] o, logic [7:0] e);
        logic [23:0] v;
        v = '0;
        for (int i = 0; i < 8; i++) begin
            v[3 * i + 1] = o[i];
            v[3 * i + 2] = e[i];
        end
        return v;
    endfunction

    // Input cells pulled out of a captured boundary vector
    function automatic logic [7:0] in_cells(logic [31:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[3 * i];
        end
        return r;
    endfunction

    // Pins against the expected drive and enable
    task automatic chk_pads(input logic [7:0] o, input logic [7:0] e);
        chk("pad_out", o, pad_out);
        chk("pad_oe", e, pad_oe);
    endtask

    // Load an instruction and compare the decoded mode
    task automatic set_ir(input logic [9:0] code, input bsid_mode_t m);
        ctl.load_ir(code, cap);
        settle();
        chk("ir capture", 10'h3fd, cap);
        chk("mode", m, active_mode);
    endtask

    // One-bit bypass: a zero first, then tdi one shift late
    task automatic chk_bypass;
        ctl.dr_shift(8, 32'h0000_00b4, dout);
        // Eight reads: the captured zero, then the first seven bits sent
        chk("bypass out", 32'h0000_0068, dout);
    endtask

    task automatic t_id_user;
        set_ir(`BSID_IR_IDCODE, MODE_IDCODE);
        ctl.dr_shift(32, 32'h0000_0000, dout);
        chk("idcode", `BSID_IDCODE_VAL, dout);
        set_ir(`BSID_IR_USERCODE, MODE_USERCODE);
        ctl.dr_shift(32, 32'h0000_0000, dout);
        chk("usercode", user_code, dout);
    endtask

    task automatic t_bypass_unlisted;
        logic [9:0] codes [5] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa,
                                  10'h3fe};
        int p0;
        p0 = pulses;
        foreach (codes[i]) begin
            set_ir(codes[i], MODE_BYPASS);
            chk_bypass();
            chk_pads(core_out, core_oe);
        end
        chk("pulses", p0, pulses);
    endtask

    task automatic t_preload_extest;
        logic o;
        @(posedge core_clk);
        pad_in <= 8'h5c;
        set_ir(`BSID_IR_SAMPLE, MODE_SAMPLE);
        ctl.dr_shift(24, mk_bsr(8'h3c, 8'hf0), dout);
        settle();
        chk("sample cells", 8'h5c, in_cells(dout));
        chk_pads(core_out, core_oe);
        ctl.ir_shift(`BSID_IR_EXTEST, cap);
        settle();
        chk("mode before update", MODE_SAMPLE, active_mode);
        chk_pads(core_out, core_oe);
        ctl.step(1'b0, 1'b0, o);
        settle();
        chk_pads(8'h3c, 8'hf0);
        @(posedge core_clk);
        pad_in <= 8'ha3;
        ctl.dr_shift(24, mk_bsr(8'h81, 8'h5a), dout);
        settle();
        chk("extest cells", 8'ha3, in_cells(dout));
        chk_pads(8'h81, 8'h5a);
    endtask

    task automatic t_clamp_highz;
        set_ir(`BSID_IR_CLAMP, MODE_CLAMP);
        chk_pads(8'h81, 8'h5a);
        chk_bypass();
        chk_pads(8'h81, 8'h5a);
        set_ir(`BSID_IR_HIGHZ, MODE_HIGHZ);
        chk("pad_oe", 8'h00, pad_oe);
        chk_bypass();
    endtask

    task automatic t_reconfig;
        int p0;
        p0 = pulses;
        @(posedge core_clk);
        core_out <= 8'h69;
        set_ir(`BSID_IR_RECONFIG, MODE_RECONFIG);
        chk("pulse cycles", p0 + 1, pulses);
        chk("pulse mode", MODE_RECONFIG, pulse_mode);
        chk_pads(8'h69, core_oe);
        @(posedge core_clk);
        trst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        trst_n <= 1'b1;
        settle();
        chk("mode after trst", MODE_IDCODE, active_mode);
        chk("pulse cycles", p0 + 1, pulses);
    endtask

    // Verdict and end of run
    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        trst_n = 1'b0;
        user_code = 32'h5a5a_c3c3;
        core_out = 8'h96;
        core_oe = 8'hc3;
        pad_in = 8'h00;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk("tdo", 1'b0, tdo);
        chk("tdo_oe", 1'b0, tdo_oe);
        chk_pads(8'h00, 8'h00);
        chk("reconfig", 1'b0, reconfig_req);
        chk("mode", MODE_IDCODE, active_mode);
        @(posedge core_clk);
        reset <= 1'b0;
        trst_n <= 1'b1;
        settle();
        chk_pads(core_out, core_oe);
        ctl.reset_tap();
        ctl.dr_shift(32, 32'h0000_0000, dout);
        chk("idcode", `BSID_IDCODE_VAL, dout);
        t_id_user();
        t_bypass_unlisted();
        t_preload_extest();
        t_clamp_highz();
        t_reconfig();
        test_done();
    end
endmodule
`default_nettype wire
